// File: hw/cache_cycle_sequencer.sv
// Cache cycle sequencer: time states, main memory start, power-up init.
// Assumes all inputs are synchronous to clk_sys and one clk_sys edge
// stands for one falling arbitration clock edge.
// Functional notes
// - State flops use one active clock edge.
// - Start on held flag; block repeats.
// - Phase A, then phase B next edge.
// - B clears A; D then hold follow.
// - Hold lasts until slow start or done.
// - Read hit: done first hold edge, idle.
// - Read hit memory sync on control-valid.
// - Drive address, mask, type, parity out.
// - Write start after data lines free.
// - Bus start after deskew, drop on ack.
// - Reads keep write start; same deskew.
// - Allow-timeout ends on ack, plus data ready on CPU/bus map reads.
// - Cache write pulse at allow-timeout end.
// - Synchronize end into memory sync, restart.
// - Power-up clears valid, fills parity.
// - Ac low clears counter, dc sets flag.
// - Index source is counter during power-up.
// - Power-up forces valid off, writes, selects.
// - Power-up write data forced to ones.
// - Each pulse writes location, steps counter.
// - Overflow clears flag, ends sequence.
// - Cache index is address bits 9:2.
// - Bus map reads answer with map done.
`timescale 1ns/10ps
`include "cache_seq_defines.svh"
module cache_cycle_sequencer (
    // Clock and reset
    input logic clk_sys,
    input logic arst_n,
    // Locked-in access request
    input logic access_request,
    input cache_seq_pkg::request_t req_in,
    input logic [`ADDR_W-1:0] addr_in,
    input logic [3:0] byte_mask_in,
    input logic [1:0] cycle_type_in,
    input logic [`DATA_W-1:0] wdata_in,
    input logic [1:0] group_sel_in,
    input logic [3:0] cs_in_n,
    // Cache decision inputs
    input logic read_hit,
    input logic control_valid,
    // Main memory bus responses
    input logic data_lines_busy,
    input logic address_acknowledged,
    input logic mem_data_ready,
    // Power status, active low
    input logic ac_power_low_n,
    input logic dc_power_low_n,
    // Time states
    output logic cycle_held_flag,
    output logic phase_a_flag,
    output logic phase_b_flag,
    output logic phase_c_decode,
    output logic phase_d_flag,
    output logic decision_hold_state,
    output logic slow_start_flag,
    output logic cycle_complete_flag,
    // Answers to processor and bus map
    output logic memory_sync_response,
    output logic bus_map_done,
    // Main memory bus
    output cache_seq_pkg::main_bus_t main_bus,
    output logic [`DATA_W-1:0] main_wdata,
    output logic main_wdata_oe,
    output logic write_start_flag,
    output logic bus_start_drive,
    output logic allow_timeout,
    output logic cache_write_pulse,
    output logic slow_memory_sync,
    output logic timing_restart,
    // Cache store control
    output logic power_up_flag,
    output logic [`INIT_CNT_W-1:0] cache_index,
    output logic address_mux_select_low,
    output logic write_ok,
    output logic [1:0] group_write_select,
    output logic [1:0] valid_input_n,
    output logic [3:0] chip_select_n,
    output logic [`DATA_W-1:0] write_mux_data,
    output logic init_write_pulse
);
    cache_seq_pkg::request_t req_q;
    cache_seq_pkg::slow_state_t slow_q;
    logic seq_run_q, sent_q, ack_seen_q, ready_seen_q, sync_stage_q;
    logic start, hit_now, decide_ok, slow_set, done_set, negate, need_data;
    logic deskew_run, deskew_elapsed, start_set, hit_answer;
    logic pup_flag, pup_pulse;
    logic [`INIT_CNT_W-1:0] pup_index;

    // A new sequence only from a fully idle cycle
    assign start = cycle_held_flag && !seq_run_q && !slow_start_flag && !phase_b_flag
        && !phase_d_flag && !decision_hold_state && !cycle_complete_flag;
    assign hit_now = read_hit && !req_q.is_write;
    assign decide_ok = !req_q.cpu || control_valid;
    assign slow_set = decision_hold_state && !slow_start_flag && !hit_now && decide_ok;
    assign done_set = (decision_hold_state && hit_now && !slow_start_flag)
        || timing_restart;
    assign need_data = !req_q.is_write && (req_q.cpu || req_q.bus_map);
    assign negate = allow_timeout && (ack_seen_q || address_acknowledged)
        && (!need_data || ready_seen_q || mem_data_ready);
    assign hit_answer = hit_now && (phase_d_flag || decision_hold_state) && !sent_q
        && !cycle_complete_flag;
    assign deskew_run = slow_start_flag && write_start_flag
        && (slow_q == cache_seq_pkg::SLOW_ARM);
    assign start_set = (slow_q == cache_seq_pkg::SLOW_ARM) && deskew_elapsed;

    // Lock and capture of the request; done releases it, a new request is captured only once released
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cycle_held_flag <= 1'b0;
            req_q <= '0;
            main_bus <= '0;
            main_wdata <= '0;
        end else begin
            cycle_held_flag <= (access_request && !cycle_held_flag)
                || (cycle_held_flag && !cycle_complete_flag);
            if (access_request && !cycle_held_flag) begin
                req_q <= req_in;
                main_bus.addr <= addr_in[`BUS_ADDR_MSB:`BUS_ADDR_LSB];
                main_bus.byte_mask <= byte_mask_in;
                main_bus.cycle_type <= cycle_type_in;
                main_bus.parity <= ^addr_in[`BUS_ADDR_MSB:`BUS_ADDR_LSB];
                main_wdata <= wdata_in;
            end
        end
    end

    // Time state chain A, AB, C, D, hold; done clears it whole
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_a_flag <= 1'b0;
            phase_b_flag <= 1'b0;
            phase_c_decode <= 1'b0;
            phase_d_flag <= 1'b0;
            decision_hold_state <= 1'b0;
            seq_run_q <= 1'b0;
        end else if (cycle_complete_flag) begin
            phase_a_flag <= 1'b0;
            phase_b_flag <= 1'b0;
            phase_c_decode <= 1'b0;
            phase_d_flag <= 1'b0;
            decision_hold_state <= 1'b0;
            seq_run_q <= 1'b0;
        end else begin
            phase_a_flag <= start || (phase_a_flag && !phase_b_flag);
            phase_b_flag <= phase_a_flag;
            phase_c_decode <= phase_b_flag && phase_a_flag;
            phase_d_flag <= phase_b_flag && !phase_a_flag;
            decision_hold_state <= phase_d_flag
                || (decision_hold_state && !slow_set && !done_set);
            seq_run_q <= seq_run_q || start;
        end
    end

    // Decision outcome: slow start or done pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slow_start_flag <= 1'b0;
            cycle_complete_flag <= 1'b0;
        end else begin
            slow_start_flag <= !cycle_complete_flag && (slow_start_flag || slow_set);
            cycle_complete_flag <= done_set && !cycle_complete_flag;
        end
    end

    // Processor and bus map answers, at most one hit answer per cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            memory_sync_response <= 1'b0;
            bus_map_done <= 1'b0;
            sent_q <= 1'b0;
        end else begin
            memory_sync_response <= req_q.cpu && ((hit_answer && control_valid)
                || slow_memory_sync);
            bus_map_done <= req_q.bus_map && !req_q.is_write
                && (hit_answer || slow_memory_sync);
            sent_q <= !cycle_complete_flag && (sent_q
                || (hit_answer && (control_valid || !req_q.cpu)));
        end
    end

    // Write start: reads hold it all cycle, writes wait for free data lines
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            write_start_flag <= 1'b0;
            main_wdata_oe <= 1'b0;
        end else begin
            write_start_flag <= cycle_held_flag && !cycle_complete_flag
                && (!req_q.is_write || write_start_flag
                || (slow_start_flag && !data_lines_busy));
            main_wdata_oe <= cycle_held_flag && !cycle_complete_flag && req_q.is_write
                && (write_start_flag || (slow_start_flag && !data_lines_busy));
        end
    end

    deskew_timer u_deskew (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .run(deskew_run),
        .elapsed(deskew_elapsed)
    );

    // Main memory cycle progress
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slow_q <= cache_seq_pkg::SLOW_IDLE;
        end else begin
            unique case (slow_q)
                cache_seq_pkg::SLOW_IDLE: if (slow_set) slow_q <= cache_seq_pkg::SLOW_ARM;
                cache_seq_pkg::SLOW_ARM: if (start_set) slow_q <= cache_seq_pkg::SLOW_BUS;
                cache_seq_pkg::SLOW_BUS: if (negate) slow_q <= cache_seq_pkg::SLOW_SYNC;
                cache_seq_pkg::SLOW_SYNC: begin
                    if (cycle_complete_flag) slow_q <= cache_seq_pkg::SLOW_IDLE;
                end
            endcase
        end
    end

    // Bus start and the allow-timeout window it opens
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_start_drive <= 1'b0;
            allow_timeout <= 1'b0;
            ack_seen_q <= 1'b0;
            ready_seen_q <= 1'b0;
        end else begin
            bus_start_drive <= start_set || (bus_start_drive && !address_acknowledged);
            allow_timeout <= start_set || (allow_timeout && !negate);
            ack_seen_q <= !start_set && (ack_seen_q || (allow_timeout && address_acknowledged));
            ready_seen_q <= !start_set && (ready_seen_q || (allow_timeout && mem_data_ready));
        end
    end

    // End of allow-timeout: write pulse, then staged into sync and restart
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cache_write_pulse <= 1'b0;
            sync_stage_q <= 1'b0;
            slow_memory_sync <= 1'b0;
            timing_restart <= 1'b0;
        end else begin
            cache_write_pulse <= negate;
            sync_stage_q <= negate;
            slow_memory_sync <= sync_stage_q;
            timing_restart <= slow_memory_sync;
        end
    end

    power_up_init u_pup (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ac_power_low_n(ac_power_low_n),
        .dc_power_low_n(dc_power_low_n),
        .power_up_flag(pup_flag),
        .init_index(pup_index),
        .init_pulse(pup_pulse)
    );

    // Store controls; one register stage keeps index and pulse aligned
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_up_flag <= 1'b1;
            cache_index <= '0;
            address_mux_select_low <= 1'b1;
            write_ok <= 1'b1;
            group_write_select <= `GROUP_ALL;
            valid_input_n <= `VALID_OFF_N;
            chip_select_n <= `CS_ALL_ON_N;
            write_mux_data <= `WMUX_ONES;
            init_write_pulse <= 1'b0;
        end else begin
            power_up_flag <= pup_flag;
            cache_index <= pup_flag ? pup_index : addr_in[`IDX_MSB:`IDX_LSB];
            address_mux_select_low <= pup_flag;
            write_ok <= pup_flag || negate;
            group_write_select <= pup_flag ? `GROUP_ALL : group_sel_in;
            valid_input_n <= pup_flag ? `VALID_OFF_N : ~group_sel_in;
            chip_select_n <= pup_flag ? `CS_ALL_ON_N : cs_in_n;
            write_mux_data <= pup_flag ? `WMUX_ONES : wdata_in;
            init_write_pulse <= pup_pulse && pup_flag;
        end
    end

    localparam int DESKEW_PAST = `DESKEW_CYC;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_walk;
        (phase_a_flag && phase_b_flag) ##1 (!phase_a_flag && phase_b_flag && phase_c_decode)
            ##1 (phase_d_flag && !phase_b_flag) ##1 (decision_hold_state && !phase_d_flag);
    endsequence
    sequence s_restart;
        ##2 timing_restart ##1 cycle_complete_flag;
    endsequence

    property p_phase_b;
        $rose(phase_a_flag) |=> phase_b_flag;
    endproperty
    a_phase_b: assert property (p_phase_b)
        else $error("phase B did not follow phase A");

    property p_walk;
        $rose(phase_a_flag) && !cycle_complete_flag |=> s_walk;
    endproperty
    a_walk: assert property (p_walk)
        else $error("time state chain out of order");

    property p_block;
        (phase_b_flag || phase_d_flag || decision_hold_state || slow_start_flag)
            |=> !$rose(phase_a_flag);
    endproperty
    a_block: assert property (p_block)
        else $error("second sequence started in one cycle");

    property p_hold;
        decision_hold_state && !cycle_complete_flag
            |=> decision_hold_state || slow_start_flag || cycle_complete_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold ended without slow start or done");

    property p_hit_done;
        decision_hold_state && hit_now && !slow_start_flag && !cycle_complete_flag
            |=> cycle_complete_flag ##1 !decision_hold_state && !phase_a_flag;
    endproperty
    a_hit_done: assert property (p_hit_done)
        else $error("read hit did not complete");

    property p_deskew;
        $rose(bus_start_drive) |-> $past(deskew_run, DESKEW_PAST) && slow_start_flag;
    endproperty
    a_deskew: assert property (p_deskew)
        else $error("bus start raised without deskew");

    property p_ack_drop;
        bus_start_drive && address_acknowledged |=> !bus_start_drive;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("bus start held after acknowledge");

    property p_restart;
        $fell(allow_timeout) |-> cache_write_pulse and s_restart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not follow allow-timeout end");

    property p_pup_force;
        power_up_flag |-> write_mux_data == `WMUX_ONES && chip_select_n == `CS_ALL_ON_N
            && valid_input_n == `VALID_OFF_N;
    endproperty
    a_pup_force: assert property (p_pup_force)
        else $error("power-up forcing missing");
endmodule

// File: hw/deskew_timer.sv
// Deskew delay counter for the main memory bus start.
// Assumes run is a registered level that stays high until the delay is used.
`timescale 1ns/10ps
`include "cache_seq_defines.svh"
module deskew_timer (
    // Clock and reset
    input logic clk_sys,
    input logic arst_n,
    // Control
    input logic run,
    output logic elapsed
);
    logic [`DESKEW_W-1:0] cnt_q;

    // Counts while run is high, saturates at the last step
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != `DESKEW_LAST) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Decoded, so the start flop fires exactly one deskew after run
    assign elapsed = run && (cnt_q == `DESKEW_LAST);
endmodule

// File: hw/power_up_init.sv
// Power-up initializer: walks an index over every cache location.
// Assumes the power-low inputs are synchronous to clk_sys.
`timescale 1ns/10ps
`include "cache_seq_defines.svh"
module power_up_init (
    // Clock and reset
    input logic clk_sys,
    input logic arst_n,
    // Power status, active low
    input logic ac_power_low_n,
    input logic dc_power_low_n,
    // Initializer state
    output logic power_up_flag,
    output logic [`INIT_CNT_W-1:0] init_index,
    output logic init_pulse
);
    logic [`INIT_DIV_W-1:0] div_q;
    logic tick;
    logic overflow;

    assign tick = (div_q == `INIT_DIV_LAST);
    assign overflow = init_pulse && (init_index == `INIT_CNT_LAST);

    // Pulse oscillator, held while ac power is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
        end else if (!ac_power_low_n || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // One write pulse per oscillator period while initializing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_pulse <= 1'b0;
        end else begin
            init_pulse <= tick && ac_power_low_n && power_up_flag && !init_pulse;
        end
    end

    // Index counter: cleared by ac low, stepped after each write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_index <= '0;
        end else if (!ac_power_low_n) begin
            init_index <= '0;
        end else if (init_pulse) begin
            init_index <= init_index + 1'b1;
        end
    end

    // Flag: set by dc low (set wins), cleared on counter overflow
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_up_flag <= 1'b1;
        end else if (!dc_power_low_n) begin
            power_up_flag <= 1'b1;
        end else if (overflow) begin
            power_up_flag <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_index_step;
        init_pulse && ac_power_low_n |=> init_index == $past(init_index) + 1'b1;
    endproperty
    a_index_step: assert property (p_index_step)
        else $error("init index did not step after write pulse");

    property p_overflow_ends;
        overflow && dc_power_low_n |=> !power_up_flag ##1 !init_pulse [*4];
    endproperty
    a_overflow_ends: assert property (p_overflow_ends)
        else $error("initialization did not stop at overflow");
endmodule

// File: pkg/cache_seq_defines.svh
// Constants shared by the cache cycle sequencer design files.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef CACHE_SEQ_DEFINES_SVH
`define CACHE_SEQ_DEFINES_SVH

// Address and data layout
`define ADDR_W 22
`define BUS_ADDR_LSB 2
`define BUS_ADDR_MSB 21
`define IDX_LSB 2
`define IDX_MSB 9
`define DATA_W 16

// Timing
`define CLK_PERIOD_NS 20
`define DESKEW_NS 100
`define DESKEW_CYC ((`DESKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DESKEW_W 3
`define DESKEW_LAST 3'(`DESKEW_CYC - 1)

// Power-up initializer
`define INIT_CNT_W 8
`define INIT_CNT_LAST 8'hff
`define INIT_DIV_W 3
`define INIT_DIV_LAST 3'h3

// Forced values during initialization
`define WMUX_ONES 16'hffff
`define CS_ALL_ON_N 4'h0
`define VALID_OFF_N 2'h3
`define GROUP_ALL 2'h3

`endif

// File: pkg/cache_seq_pkg.sv
// Types shared by the cache cycle sequencer design files.
// Assumes cache_seq_defines.svh is on the include path.
`include "cache_seq_defines.svh"
package cache_seq_pkg;

    // Kind of access locked in for the current cycle
    typedef struct packed {
        logic is_write;
        logic cpu;
        logic bus_map;
        logic controller;
    } request_t;

    // Address and control driven onto the main memory bus
    typedef struct packed {
        logic [`BUS_ADDR_MSB-`BUS_ADDR_LSB:0] addr;
        logic [3:0] byte_mask;
        logic [1:0] cycle_type;
        logic parity;
    } main_bus_t;

    // Main memory cycle progress
    typedef enum logic [1:0] {
        SLOW_IDLE,
        SLOW_ARM,
        SLOW_BUS,
        SLOW_SYNC
    } slow_state_t;

endpackage

// File: tb/cache_cycle_sequencer_test.sv
// Self-checking bench for the cache cycle sequencer.
// Assumes mem_partner stands in for main memory on the far side.
`timescale 1ns/10ps
module cache_cycle_sequencer_test;
    // Stimulus and observed signals
    logic clk_sys, arst_n, access_request, read_hit, control_valid, busy_load;
    logic ac_power_low_n, dc_power_low_n, data_lines_busy, address_acknowledged, mem_data_ready;
    logic cycle_held_flag, phase_a_flag, phase_b_flag, phase_c_decode, phase_d_flag;
    logic decision_hold_state, slow_start_flag, cycle_complete_flag, memory_sync_response;
    logic bus_map_done, main_wdata_oe, write_start_flag, bus_start_drive, allow_timeout;
    logic cache_write_pulse, slow_memory_sync, timing_restart, power_up_flag;
    logic address_mux_select_low, write_ok, init_write_pulse;
    cache_seq_pkg::request_t req_in;
    cache_seq_pkg::main_bus_t main_bus;
    logic [21:0] addr_in;
    logic [3:0] byte_mask_in, cs_in_n, chip_select_n;
    logic [1:0] cycle_type_in, group_sel_in, group_write_select, valid_input_n;
    logic [15:0] wdata_in, main_wdata, write_mux_data;
    logic [7:0] cache_index;
    int failures, num_checks, n;

    cache_cycle_sequencer dut (.clk_sys, .arst_n, .access_request, .req_in, .addr_in,
        .byte_mask_in, .cycle_type_in, .wdata_in, .group_sel_in, .cs_in_n, .read_hit,
        .control_valid, .data_lines_busy, .address_acknowledged, .mem_data_ready,
        .ac_power_low_n, .dc_power_low_n, .cycle_held_flag, .phase_a_flag, .phase_b_flag,
        .phase_c_decode, .phase_d_flag, .decision_hold_state, .slow_start_flag,
        .cycle_complete_flag, .memory_sync_response, .bus_map_done, .main_bus, .main_wdata,
        .main_wdata_oe, .write_start_flag, .bus_start_drive, .allow_timeout,
        .cache_write_pulse, .slow_memory_sync, .timing_restart, .power_up_flag, .cache_index,
        .address_mux_select_low, .write_ok, .group_write_select, .valid_input_n,
        .chip_select_n, .write_mux_data, .init_write_pulse);
    mem_partner mem (.clk_sys, .arst_n, .bus_start_drive, .allow_timeout, .busy_load,
        .address_acknowledged, .mem_data_ready, .data_lines_busy);

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] trace();
        return {phase_a_flag, phase_b_flag, phase_c_decode, phase_d_flag, decision_hold_state,
                memory_sync_response, bus_map_done, cycle_complete_flag};
    endfunction

    function automatic logic sig(input int k);
        case (k)
            0: return slow_start_flag;
            1: return bus_start_drive;
            2: return memory_sync_response;
            3: return write_start_flag;
            default: return ~allow_timeout;
        endcase
    endfunction

    // Count cycles until the chosen signal is high; a hang ends the run
    task automatic wait_sig(input int k);
        n = 0;
        while (sig(k) !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000) begin
            failures++;
            stop_test();
        end
    endtask

    task automatic issue(input logic [3:0] r, input logic keep);
        req_in = r;
        busy_load = r[3];
        access_request = 1'b1;
        @(negedge clk_sys);
        access_request = keep;
        busy_load = 1'b0;
    endtask

    // Walk the whole init and count its write pulses
    task automatic init_run();
        int p;
        p = 0;
        n = 0;
        while (power_up_flag === 1'b1 && n < 3000) begin
            check({address_mux_select_low, write_ok, group_write_select, valid_input_n,
                   chip_select_n}, 10'h3f0);
            check(write_mux_data, 16'hffff);
            if (init_write_pulse === 1'b1) begin
                check(cache_index, p[7:0]);
                p++;
            end
            @(negedge clk_sys);
            n++;
        end
        check(p, 256);
        check(power_up_flag, 1'b0);
        if (n >= 3000) begin
            failures++;
            stop_test();
        end
    endtask

    // Request held high all along, so a second sequence would show up in the trace
    task automatic hit_case(input logic [3:0] r);
        logic [7:0] exp [8];
        exp = '{8'h00, 8'h80, 8'hc0, 8'h60, 8'h10, 8'h0c, 8'h01, 8'h00};
        if (r[1]) exp[5] = 8'h0a;
        read_hit = 1'b1;
        issue(r, 1'b1);
        for (int k = 0; k < 8; k++) begin
            check(trace(), exp[k]);
            if (k == 0) begin
                check(main_bus, {addr_in[21:2], byte_mask_in, cycle_type_in,
                    ^addr_in[21:2]});
            end
            if (k == 7) access_request = 1'b0;
            @(negedge clk_sys);
        end
        check({cycle_held_flag, cache_index}, {1'b0, addr_in[9:2]});
        // Outside power-up the store controls follow their normal sources
        check({address_mux_select_low, group_write_select, chip_select_n, write_mux_data},
            {1'b0, group_sel_in, cs_in_n, wdata_in});
    endtask

    // Miss or write: deskew, memory handshake, then restart
    task automatic slow_case(input logic [3:0] r, input int fall);
        read_hit = 1'b0;
        issue(r, 1'b0);
        wait_sig(0);
        wait_sig(3);
        if (r[3]) check({data_lines_busy, main_wdata_oe, main_wdata}, {2'b01, wdata_in});
        wait_sig(1);
        check(n, 5);
        wait_sig(4);
        check(n, fall);
        check({cache_write_pulse, write_ok, bus_start_drive}, 3'b110);
        @(negedge clk_sys);
        check(slow_memory_sync, 1'b1);
        wait_sig(2);
        check({timing_restart, n[3:0]}, 5'h11);
        @(negedge clk_sys);
        check(cycle_complete_flag, 1'b1);
        @(negedge clk_sys);
        check(cycle_held_flag, 1'b0);
    endtask

    initial begin
        arst_n = 1'b0;
        access_request = 1'b0;
        read_hit = 1'b0;
        control_valid = 1'b1;
        busy_load = 1'b0;
        ac_power_low_n = 1'b1;
        dc_power_low_n = 1'b1;
        req_in = '0;
        addr_in = 22'h2a5a5c;
        byte_mask_in = 4'h5;
        cycle_type_in = 2'h2;
        wdata_in = 16'h3c69;
        group_sel_in = 2'h1;
        cs_in_n = 4'ha;
        failures = 0;
        num_checks = 0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        init_run();
        hit_case(4'b0100);
        hit_case(4'b0010);
        slow_case(4'b0100, 6);
        slow_case(4'b1100, 3);
        // Brief dc power loss after init restarts it; ac low mid-init must then clear the counter to zero
        dc_power_low_n = 1'b0;
        @(negedge clk_sys);
        dc_power_low_n = 1'b1;
        // The top-level flag is one register stage behind the initializer
        @(negedge clk_sys);
        check(power_up_flag, 1'b1);
        repeat (40) @(negedge clk_sys);
        ac_power_low_n = 1'b0;
        @(negedge clk_sys);
        repeat (8) begin
            @(negedge clk_sys);
            check(init_write_pulse, 1'b0);
        end
        ac_power_low_n = 1'b1;
        init_run();
        stop_test();
    end
endmodule

// File: tb/mem_partner.sv
// Main memory model that answers the sequencer's bus start.
// Assumes bus start and allow-timeout are clk_sys flops in the sequencer.
`timescale 1ns/10ps
module mem_partner #(
    parameter int ACK_DLY = 2,
    parameter int RDY_DLY = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // From the sequencer and the bench
    input wire logic bus_start_drive,
    input wire logic allow_timeout,
    input wire logic busy_load,
    // Answers, idle low when released
    output logic address_acknowledged,
    output logic mem_data_ready,
    output logic data_lines_busy
);
    int scnt, rcnt, bcnt;

    // Acknowledge only once start has stood a while
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scnt <= 0;
        end else begin
            scnt <= bus_start_drive ? scnt + 1 : 0;
        end
    end
    assign address_acknowledged = bus_start_drive && scnt >= ACK_DLY;

    // Data ready trails the acknowledge, so a hasty sequencer gets caught
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rcnt <= 0;
        end else begin
            rcnt <= (allow_timeout && (address_acknowledged || rcnt > 0)) ? rcnt + 1 : 0;
        end
    end
    assign mem_data_ready = allow_timeout && rcnt >= RDY_DLY;

    // Data lines stay occupied ten cycles after the bench loads them
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bcnt <= 0;
        end else begin
            bcnt <= busy_load ? 10 : (bcnt > 0 ? bcnt - 1 : 0);
        end
    end
    assign data_lines_busy = bcnt != 0;
endmodule
